//--- isl_cfg.svh
// constants for the instruction slotting stage
// assumes a four-slot aligned fetch block and four execution pipes
`ifndef ISL_CFG_SVH
`define ISL_CFG_SVH

// ----------------------------------------------------------------
// block geometry
// ----------------------------------------------------------------
`define ISL_SLOTS 4
`define ISL_IDX_W 2
`define ISL_WORD_W 32
`define ISL_REG_W 5

// ----------------------------------------------------------------
// pipe mask bit positions
// ----------------------------------------------------------------
`define ISL_M_E0 0
`define ISL_M_E1 1
`define ISL_M_FA 2
`define ISL_M_FM 3
`define ISL_PIPES 4

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define ISL_ZERO_REG 5'h1F
`define ISL_MASK_NONE 4'h0
`define ISL_MASK_E0 4'h1
`define ISL_MASK_E1 4'h2
`define ISL_MASK_INT 4'h3
`define ISL_MASK_FA 4'h4
`define ISL_MASK_FM 4'h8
`define ISL_MASK_FP 4'hC

`endif

//--- isl_pkg.sv
// types shared by the slotting stage and its classifier
// assumes isl_cfg.svh is on the include path
`include "isl_cfg.svh"

package isl_pkg;

    // ----------------------------------------------------------------
    // instruction classes, as pre-decoded by the fetch buffer
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ISL_LOAD_CLASS = 5'h00,
        ISL_STORE_CLASS = 5'h01,
        ISL_BARRIER_LOCK_CLASS = 5'h02,
        ISL_READ_FLAG_CLASS = 5'h03,
        ISL_INTERNAL_REG_MOVE_CLASS = 5'h04,
        ISL_INT_COND_BRANCH_CLASS = 5'h05,
        ISL_FP_COND_BRANCH_CLASS = 5'h06,
        ISL_JUMP_CALL_CLASS = 5'h07,
        ISL_INT_ADD_CLASS = 5'h08,
        ISL_INT_LOGIC_CLASS = 5'h09,
        ISL_SIGN_EXTEND_CLASS = 5'h0A,
        ISL_SHIFT_CLASS = 5'h0B,
        ISL_COND_MOVE_CLASS = 5'h0C,
        ISL_INT_COMPARE_CLASS = 5'h0D,
        ISL_MUL_LONG_CLASS = 5'h0E,
        ISL_MUL_QUAD_CLASS = 5'h0F,
        ISL_MUL_HIGH_CLASS = 5'h10,
        ISL_FP_ADD_CLASS = 5'h11,
        ISL_FP_DIVIDE_CLASS = 5'h12,
        ISL_FP_MULTIPLY_CLASS = 5'h13,
        ISL_FP_COPY_SIGN_CLASS = 5'h14,
        ISL_MISC_CLASS = 5'h15
    } isl_class_e;

    // pipe given to a forwarded instruction
    typedef enum logic [2:0] {
        ISL_PIPE_NONE = 3'h0,
        ISL_INT_PIPE_ZERO = 3'h1,
        ISL_INT_PIPE_ONE = 3'h2,
        ISL_FP_ADD_PIPE = 3'h3,
        ISL_FP_MUL_PIPE = 3'h4
    } isl_pipe_e;

    // one slot of the aligned fetch block
    typedef struct packed {
        logic vld;
        isl_class_e cls;
        logic unaligned;
        logic [`ISL_REG_W-1:0] dest;
        logic ipr_pipe_one;
        logic pred_taken;
        logic [`ISL_WORD_W-1:0] word;
    } isl_slot_s;

    // static facts about one slot
    typedef struct packed {
        logic [`ISL_PIPES-1:0] mask;
        logic is_int;
        logic is_fp;
        logic is_load;
        logic is_store;
        logic is_cbr;
        logic is_jump;
        logic noop;
    } isl_info_s;

    // group held at the issue point
    typedef struct packed {
        logic [`ISL_SLOTS-1:0] left;
        isl_pipe_e [`ISL_SLOTS-1:0] pipe;
        isl_slot_s [`ISL_SLOTS-1:0] ins;
    } isl_group_s;

endpackage

//--- isl_classify.sv
// classifier: permitted pipes and kind of one fetch-block slot
// assumes the slot's class field is already decoded upstream
`timescale 1ns/1ps
`include "isl_cfg.svh"

module isl_classify (
    input wire isl_pkg::isl_slot_s i_slot,
    output isl_pkg::isl_info_s o_info
);

    // ----------------------------------------------------------------
    // class to pipe table
    // ----------------------------------------------------------------
    always_comb begin
        o_info = '0;
        case (i_slot.cls)
            isl_pkg::ISL_LOAD_CLASS: begin
                o_info.mask = `ISL_MASK_INT;
                o_info.is_load = 1'b1;
            end
            isl_pkg::ISL_STORE_CLASS: begin
                o_info.mask = `ISL_MASK_E0;
                o_info.is_store = 1'b1;
            end
            isl_pkg::ISL_BARRIER_LOCK_CLASS,
            isl_pkg::ISL_READ_FLAG_CLASS: o_info.mask = `ISL_MASK_E0;
            isl_pkg::ISL_INTERNAL_REG_MOVE_CLASS: begin
                o_info.mask = i_slot.ipr_pipe_one ? `ISL_MASK_E1 : `ISL_MASK_E0;
            end
            isl_pkg::ISL_INT_COND_BRANCH_CLASS: begin
                o_info.mask = `ISL_MASK_E1;
                o_info.is_cbr = 1'b1;
            end
            isl_pkg::ISL_JUMP_CALL_CLASS: begin
                o_info.mask = `ISL_MASK_E1;
                o_info.is_jump = 1'b1;
            end
            isl_pkg::ISL_INT_ADD_CLASS,
            isl_pkg::ISL_INT_LOGIC_CLASS,
            isl_pkg::ISL_COND_MOVE_CLASS,
            isl_pkg::ISL_INT_COMPARE_CLASS: o_info.mask = `ISL_MASK_INT;
            isl_pkg::ISL_SHIFT_CLASS,
            isl_pkg::ISL_SIGN_EXTEND_CLASS,
            isl_pkg::ISL_MUL_LONG_CLASS,
            isl_pkg::ISL_MUL_QUAD_CLASS,
            isl_pkg::ISL_MUL_HIGH_CLASS,
            isl_pkg::ISL_MISC_CLASS: o_info.mask = `ISL_MASK_E0;
            isl_pkg::ISL_FP_COND_BRANCH_CLASS: begin
                o_info.mask = `ISL_MASK_FA;
                o_info.is_cbr = 1'b1;
            end
            isl_pkg::ISL_FP_ADD_CLASS,
            isl_pkg::ISL_FP_DIVIDE_CLASS: o_info.mask = `ISL_MASK_FA;
            isl_pkg::ISL_FP_MULTIPLY_CLASS: o_info.mask = `ISL_MASK_FM;
            isl_pkg::ISL_FP_COPY_SIGN_CLASS: o_info.mask = `ISL_MASK_FP;
            default: o_info.mask = `ISL_MASK_NONE;
        endcase
        // unaligned load into the zero register uses no pipe
        if (i_slot.cls == isl_pkg::ISL_LOAD_CLASS && i_slot.unaligned && i_slot.dest == `ISL_ZERO_REG) begin
            o_info.mask = `ISL_MASK_NONE;
            o_info.is_load = 1'b0;
            o_info.noop = 1'b1;
        end
        // integer means integer pipes only, floating means any fp pipe
        o_info.is_fp = |o_info.mask[`ISL_M_FM:`ISL_M_FA];
        o_info.is_int = (|o_info.mask[`ISL_M_E1:`ISL_M_E0]) && !o_info.is_fp;
    end

endmodule

//--- isl_slotter.sv
// instruction slotting stage: stage-2 fetch block in, in-order group out
// assumes a pre-decoded fetch block from the buffer and an issue check
// that reports, each cycle, which held instructions have issued
`timescale 1ns/1ps
`include "isl_cfg.svh"

// Behaviour
// - ordinary loads go to either integer pipe
// - stores, barriers, locks, flag reads: pipe zero
// - internal register moves steered by target register
// - integer branches and jumps: pipe one only
// - add, logic, cmove, compare: either integer pipe
// - shifts, sign extend, multiplies, misc: pipe zero
// - fp branch, divide, other operates: fp add
// - fp multiply to mul pipe; copy-sign either
// - unaligned load to zero register takes no pipe
// - start at lowest valid slot, address order
// - dual-pipe integer: zero, else one when needed
// - dual-pipe fp: add pipe unless already taken
// - mark pipe taken; stop when none free
// - group is contiguous, always in program order
// - slotter removes all static pipe conflicts
// - no load and store in one group
// - discard rest after taken branch or jump
// - after not-taken branch, no further branch
// - split int-fp-int-int and fp-int-int blocks after two
// - integer means integer pipes only
// - later group waits until held group issued
// - issued instructions leave, never held again
module isl_slotter (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_blk_valid,
    input wire isl_pkg::isl_slot_s [`ISL_SLOTS-1:0] i_blk,
    output logic o_blk_ready,
    input wire logic i_abort,
    input wire logic [`ISL_SLOTS-1:0] i_issued,
    output isl_pkg::isl_group_s o_group
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    isl_pkg::isl_slot_s [`ISL_SLOTS-1:0] blk_q;
    logic blk_vld_q;
    logic [`ISL_SLOTS-1:0] done_q;
    isl_pkg::isl_group_s grp_q;
    isl_pkg::isl_info_s [`ISL_SLOTS-1:0] info;
    logic [`ISL_SLOTS-1:0] live;
    logic [`ISL_SLOTS-1:0] sel;
    logic [`ISL_SLOTS-1:0] disc;
    isl_pkg::isl_pipe_e [`ISL_SLOTS-1:0] pick;
    logic [`ISL_SLOTS-1:0] left_after;
    logic advance;
    logic block_spent;
    logic split_case;

    // ----------------------------------------------------------------
    // classification of each slot
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `ISL_SLOTS; g = g + 1) begin : gen_cls
            isl_classify u_classify (
                .i_slot(blk_q[g]),
                .o_info(info[g])
            );
        end
    endgenerate

    // slots still waiting in stage 2
    always_comb begin
        for (int i = 0; i < `ISL_SLOTS; i++) begin
            live[i] = blk_vld_q && blk_q[i].vld && !done_q[i];
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // next live integer slot after idx can use pipe zero only
    function automatic logic next_int_zero_only(
        input logic [`ISL_SLOTS-1:0] lv,
        input isl_pkg::isl_info_s [`ISL_SLOTS-1:0] inf,
        input int idx
    );
        logic found;
        logic res;
        found = 1'b0;
        res = 1'b0;
        for (int j = 0; j < `ISL_SLOTS; j++) begin
            if (j > idx && !found && lv[j] && inf[j].is_int) begin
                found = 1'b1;
                res = (inf[j].mask == `ISL_MASK_E0);
            end
        end
        return res;
    endfunction

    // pipe name for one mask bit
    function automatic isl_pkg::isl_pipe_e pipe_of(input logic [`ISL_PIPES-1:0] m);
        isl_pkg::isl_pipe_e p;
        p = isl_pkg::ISL_PIPE_NONE;
        if (m[`ISL_M_E0]) begin
            p = isl_pkg::ISL_INT_PIPE_ZERO;
        end else if (m[`ISL_M_E1]) begin
            p = isl_pkg::ISL_INT_PIPE_ONE;
        end else if (m[`ISL_M_FA]) begin
            p = isl_pkg::ISL_FP_ADD_PIPE;
        end else if (m[`ISL_M_FM]) begin
            p = isl_pkg::ISL_FP_MUL_PIPE;
        end
        return p;
    endfunction

    // ----------------------------------------------------------------
    // arrangement detection
    // ----------------------------------------------------------------

    // whole untouched block, checked from its lowest address
    always_comb begin
        split_case = 1'b0;
        if (live == {`ISL_SLOTS{1'b1}} &&
            info[0].is_int && info[1].is_fp && info[2].is_int && info[3].is_int) begin
            split_case = 1'b1;
        end
        if (live[0] && live[1] && live[2] && !done_q[3] &&
            info[0].is_fp && info[1].is_int && info[2].is_int) begin
            split_case = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // slotting walk
    // ----------------------------------------------------------------
    always_comb begin
        logic [`ISL_PIPES-1:0] taken;
        logic [`ISL_PIPES-1:0] avail;
        logic [`ISL_PIPES-1:0] bit_m;
        logic stop;
        logic kill_rest;
        logic saw_load;
        logic saw_store;
        logic saw_nt_branch;
        logic [`ISL_IDX_W:0] count;
        taken = `ISL_MASK_NONE;
        avail = `ISL_MASK_NONE;
        bit_m = `ISL_MASK_NONE;
        stop = 1'b0;
        kill_rest = 1'b0;
        saw_load = 1'b0;
        saw_store = 1'b0;
        saw_nt_branch = 1'b0;
        count = '0;
        sel = '0;
        disc = '0;
        pick = {`ISL_SLOTS{isl_pkg::ISL_PIPE_NONE}};
        // address order from the lowest live slot
        for (int i = 0; i < `ISL_SLOTS; i++) begin
            if (live[i] && !stop) begin
                avail = info[i].mask & ~taken;
                bit_m = `ISL_MASK_NONE;
                if (kill_rest) begin
                    disc[i] = 1'b1;
                end else if (split_case && count == 3'h2) begin
                    stop = 1'b1;
                end else if (info[i].noop) begin
                    sel[i] = 1'b1;
                    count = count + 3'h1;
                end else if ((info[i].is_load && saw_store) || (info[i].is_store && saw_load)) begin
                    stop = 1'b1;
                end else if ((info[i].is_cbr || info[i].is_jump) && saw_nt_branch) begin
                    stop = 1'b1;
                end else if (avail == `ISL_MASK_NONE) begin
                    stop = 1'b1;
                end else begin
                    if (info[i].mask == `ISL_MASK_INT) begin
                        // zero first; one if zero taken or next int needs zero
                        if (!avail[`ISL_M_E0] ||
                            (avail[`ISL_M_E1] && next_int_zero_only(live, info, i))) begin
                            bit_m = `ISL_MASK_E1;
                        end else begin
                            bit_m = `ISL_MASK_E0;
                        end
                    end else if (info[i].mask == `ISL_MASK_FP) begin
                        bit_m = avail[`ISL_M_FA] ? `ISL_MASK_FA : `ISL_MASK_FM;
                    end else begin
                        bit_m = avail; // single permitted pipe
                    end
                    taken = taken | bit_m;
                    sel[i] = 1'b1;
                    pick[i] = pipe_of(bit_m);
                    count = count + 3'h1;
                    saw_load = saw_load | info[i].is_load;
                    saw_store = saw_store | info[i].is_store;
                    if (info[i].is_jump || (info[i].is_cbr && blk_q[i].pred_taken)) begin
                        kill_rest = 1'b1;
                    end
                    if (info[i].is_cbr && !blk_q[i].pred_taken) begin
                        saw_nt_branch = 1'b1;
                    end
                end
            end else if (live[i]) begin
                // once stopped nothing later goes
                sel[i] = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // advance control
    // ----------------------------------------------------------------

    // held group minus what issues now
    assign left_after = grp_q.left & ~i_issued;
    // new group only once the held group has fully issued
    assign advance = (left_after == '0) && !i_abort;
    // every live slot taken or discarded this cycle
    assign block_spent = advance && ((live & ~(sel | disc)) == '0);
    assign o_blk_ready = !blk_vld_q || block_spent;

    // ----------------------------------------------------------------
    // stage-2 block register
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            blk_vld_q <= 1'b0;
            blk_q <= '0;
        end else if (i_abort) begin
            blk_vld_q <= 1'b0;
        end else if (o_blk_ready) begin
            blk_vld_q <= i_blk_valid;
            blk_q <= i_blk;
        end
    end

    // slots of the current block already sent or discarded
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_q <= '0;
        end else if (i_abort || o_blk_ready) begin
            done_q <= '0;
        end else if (advance) begin
            done_q <= done_q | sel | disc;
        end
    end

    // ----------------------------------------------------------------
    // group held at the issue point
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            grp_q <= '0;
        end else if (i_abort) begin
            grp_q.left <= '0;
        end else if (advance) begin
            grp_q.left <= sel;
            grp_q.pipe <= pick;
            grp_q.ins <= blk_q;
        end else begin
            grp_q.left <= left_after;
        end
    end

    assign o_group = grp_q;

endmodule

//--- isl_slotter_props.sv
// checker for the slotting stage, bound to its top module
// assumes issue check and fetch buffer drive the inputs
`timescale 1ns/1ps
`include "isl_cfg.svh"

module isl_slotter_chk (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_blk_valid,
    input wire isl_pkg::isl_slot_s [`ISL_SLOTS-1:0] i_blk,
    input wire logic o_blk_ready,
    input wire logic i_abort,
    input wire logic [`ISL_SLOTS-1:0] i_issued,
    input wire isl_pkg::isl_group_s o_group
);
    localparam logic [2:0] PN = isl_pkg::ISL_PIPE_NONE;
    localparam logic [2:0] PZ = isl_pkg::ISL_INT_PIPE_ZERO;
    localparam logic [2:0] PO = isl_pkg::ISL_INT_PIPE_ONE;
    localparam logic [2:0] PA = isl_pkg::ISL_FP_ADD_PIPE;
    localparam logic [2:0] PM = isl_pkg::ISL_FP_MUL_PIPE;
    logic [3:0] lft, rest, keep_q;
    logic [4:0] sum;
    logic new_q, conf, nop_bad, fix_bad, has_ld, has_st;
    assign lft = o_group.left;
    assign rest = lft & ~i_issued;

    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    // what should still be held, and whether a fresh group is due
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            keep_q <= 4'h0;
            new_q <= 1'b1;
        end else begin
            keep_q <= rest;
            new_q <= (rest == 4'h0) || i_abort;
        end
    end

    // static facts about the held slots
    always_comb begin
        logic [2:0] p, want;
        logic [4:0] c;
        logic noop;
        p = 3'h0;
        want = 3'h0;
        c = 5'h00;
        noop = 1'b0;
        conf = 1'b0;
        nop_bad = 1'b0;
        fix_bad = 1'b0;
        has_ld = 1'b0;
        has_st = 1'b0;
        for (int i = 0; i < 4; i++) begin
            p = o_group.pipe[i];
            c = o_group.ins[i].cls;
            noop = c == 5'h00 && o_group.ins[i].unaligned && o_group.ins[i].dest == 5'h1F;
            case (c)
                5'h01, 5'h02, 5'h03, 5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h10, 5'h15: want = PZ;
                5'h05, 5'h07: want = PO;
                5'h06, 5'h11, 5'h12: want = PA;
                5'h13: want = PM;
                default: want = p;
            endcase
            if (lft[i]) begin
                nop_bad = nop_bad | (noop && p != PN);
                fix_bad = fix_bad | (p != want);
                has_ld = has_ld | (c == 5'h00 && !noop);
                has_st = has_st | (c == 5'h01);
                for (int j = i + 1; j < 4; j++)
                    conf = conf | (lft[j] && o_group.pipe[j] == o_group.pipe[i] && p != PN);
            end
        end
        sum = {1'b0, lft} + {1'b0, lft & (~lft + 4'h1)};
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    AST_HOLD: assert property (|rest && !i_abort |=> lft == keep_q)
        else $error("held slots changed");
    AST_INS: assert property (|rest && !i_abort |=> $stable(o_group.ins))
        else $error("held group replaced early");
    AST_ABORT: assert property (i_abort |=> lft == 4'h0)
        else $error("abort left slots held");
    AST_CONTIG: assert property (new_q |-> (sum[3:0] & lft) == 4'h0)
        else $error("group not contiguous");
    AST_CONF: assert property (!conf)
        else $error("two slots share a pipe");
    AST_NOOP: assert property (!nop_bad)
        else $error("no-op given a pipe");
    AST_FIXED: assert property (!fix_bad)
        else $error("slot in forbidden pipe");
    AST_LDST: assert property (new_q |-> !(has_ld && has_st))
        else $error("load and store grouped");
    AST_LOAD: assert property (
        i_blk_valid && o_blk_ready && !i_abort && lft == 4'h0 && i_blk[0].vld |-> ##[1:2] |lft)
        else $error("accepted block not slotted");

    cover property (new_q && lft == 4'h3);
    cover property (|rest && |(lft & i_issued));
    cover property (i_abort && |lft);
endmodule

bind isl_slotter isl_slotter_chk u_chk (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_blk_valid(i_blk_valid),
    .i_blk(i_blk),
    .o_blk_ready(o_blk_ready),
    .i_abort(i_abort),
    .i_issued(i_issued),
    .o_group(o_group)
);

//--- isl_issue_model.sv
// issue-check stand-in facing the slotter's held group
// assumes the bench sets which held slots may issue
`timescale 1ns/1ps

module isl_issue_model (
    input wire logic i_rst_b,
    input wire logic [3:0] i_left,
    input wire logic [3:0] i_allow,
    output logic [3:0] o_issued
);
    // issue only held slots that are allowed; zero allow stalls
    always_comb o_issued = i_rst_b ? (i_left & i_allow) : 4'h0;
endmodule

//--- instruction_slotting_logic_tb.sv
// self-checking bench for the slotting stage
// assumes the issue model and the checker bind are compiled
`timescale 1ns/1ps
`include "isl_cfg.svh"

module instruction_slotting_logic_tb;
    localparam logic [2:0] PN = isl_pkg::ISL_PIPE_NONE;
    localparam logic [2:0] PZ = isl_pkg::ISL_INT_PIPE_ZERO;
    localparam logic [2:0] PO = isl_pkg::ISL_INT_PIPE_ONE;
    localparam logic [2:0] PA = isl_pkg::ISL_FP_ADD_PIPE;
    localparam logic [2:0] PM = isl_pkg::ISL_FP_MUL_PIPE;
    localparam isl_pkg::isl_slot_s EMPTY = '0;
    logic i_mclk, i_rst_b, i_blk_valid, o_blk_ready, i_abort;
    isl_pkg::isl_slot_s [3:0] i_blk;
    logic [3:0] i_issued, allow;
    isl_pkg::isl_group_s o_group;
    int num_errors, total_checks;

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    isl_slotter dut (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_blk_valid(i_blk_valid),
        .i_blk(i_blk),
        .o_blk_ready(o_blk_ready),
        .i_abort(i_abort),
        .i_issued(i_issued),
        .o_group(o_group)
    );

    isl_issue_model u_issue (
        .i_rst_b(i_rst_b),
        .i_left(o_group.left),
        .i_allow(allow),
        .o_issued(i_issued)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic isl_pkg::isl_slot_s mk(input logic [4:0] c, input logic t);
        mk = '0;
        mk.vld = 1'b1;
        mk.cls = isl_pkg::isl_class_e'(c);
        mk.pred_taken = t;
    endfunction

    function automatic isl_pkg::isl_slot_s [3:0] blk(input isl_pkg::isl_slot_s a, b, c, d);
        blk = {d, c, b, a};
    endfunction

    // pipes of a same-class pair, slot one above slot zero
    function automatic logic [5:0] pair(input logic [4:0] c);
        case (c)
            5'h00, 5'h08, 5'h09, 5'h0C, 5'h0D: pair = {PO, PZ};
            5'h05, 5'h07: pair = {PN, PO};
            5'h06, 5'h11, 5'h12: pair = {PN, PA};
            5'h13: pair = {PN, PM};
            5'h14: pair = {PM, PA};
            default: pair = {PN, PZ};
        endcase
    endfunction

    task automatic chk_mask(input string nm, input logic [3:0] e, input logic [3:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_pipe(input string nm, input logic [2:0] e, input logic [2:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s pipe expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) begin
            @(posedge i_mclk);
            #1;
        end
    endtask

    // offer one block and wait for its first group to be shown
    task automatic send(input isl_pkg::isl_slot_s [3:0] b);
        int n;
        n = 0;
        while (o_blk_ready !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        i_blk = b;
        i_blk_valid = 1'b1;
        cyc(1);
        i_blk_valid = 1'b0;
        n = 0;
        while (o_group.left === 4'h0 && n < 10) begin
            cyc(1);
            n++;
        end
    endtask

    // check first group and its pipes, issue it, check what follows
    task automatic run(input string nm, input isl_pkg::isl_slot_s [3:0] b, input logic [3:0] l1,
                       input logic [11:0] p, input logic [3:0] l2);
        send(b);
        chk_mask({nm, " first"}, l1, o_group.left);
        for (int i = 0; i < 4; i++)
            if (l1[i])
                chk_pipe(nm, p[3*i+:3], o_group.pipe[i]);
        allow = 4'hF;
        cyc(1);
        chk_mask({nm, " next"}, l2, o_group.left);
        cyc(6);
        allow = 4'h0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_classes();
        logic [5:0] pp;
        logic [3:0] l1;
        for (int c = 0; c < 22; c++) begin
            pp = pair(5'(c));
            l1 = (pp[5:3] == PN) ? 4'h1 : 4'h3;
            run($sformatf("class %0d", c), blk(mk(5'(c), 1'b0), mk(5'(c), 1'b0), EMPTY, EMPTY), l1,
                {6'h0, pp}, (c == 7 || l1 == 4'h3) ? 4'h0 : 4'h2);
        end
        $display("class pairs done");
    endtask

    task automatic t_ipr();
        isl_pkg::isl_slot_s s;
        s = mk(5'h04, 1'b0);
        s.ipr_pipe_one = 1'b1;
        run("ipr", blk(mk(5'h04, 1'b0), s, EMPTY, EMPTY), 4'h3, {6'h0, PO, PZ}, 4'h0);
        $display("ipr steer done");
    endtask

    task automatic t_noop();
        isl_pkg::isl_slot_s s;
        s = mk(5'h00, 1'b0);
        s.unaligned = 1'b1;
        s.dest = 5'h1F;
        run("noop", blk(s, mk(5'h08, 1'b0), mk(5'h08, 1'b0), mk(5'h08, 1'b0)), 4'h7,
            {PN, PO, PZ, PN}, 4'h8);
        $display("noop done");
    endtask

    task automatic t_steer();
        run("steer", blk(mk(5'h08, 1'b0), mk(5'h11, 1'b0), mk(5'h0B, 1'b0), EMPTY), 4'h7,
            {PN, PZ, PA, PO}, 4'h0);
        $display("steer done");
    endtask

    task automatic t_ldst();
        run("ldst", blk(mk(5'h00, 1'b0), mk(5'h01, 1'b0), EMPTY, EMPTY), 4'h1,
            {9'h0, PO}, 4'h2);
        $display("load store done");
    endtask

    task automatic t_taken();
        run("taken", blk(mk(5'h08, 1'b0), mk(5'h05, 1'b1), mk(5'h08, 1'b0), mk(5'h08, 1'b0)), 4'h3,
            {6'h0, PO, PZ}, 4'h0);
        $display("taken done");
    endtask

    task automatic t_nottaken();
        run("nottaken", blk(mk(5'h05, 1'b0), mk(5'h08, 1'b0), mk(5'h06, 1'b0), EMPTY), 4'h3,
            {6'h0, PZ, PO}, 4'h4);
        $display("not taken done");
    endtask

    task automatic t_split();
        run("ifii", blk(mk(5'h08, 1'b0), mk(5'h11, 1'b0), mk(5'h08, 1'b0), mk(5'h08, 1'b0)), 4'h3,
            {6'h0, PA, PZ}, 4'hC);
        run("fiif", blk(mk(5'h11, 1'b0), mk(5'h08, 1'b0), mk(5'h08, 1'b0), mk(5'h11, 1'b0)), 4'h3,
            {6'h0, PZ, PA}, 4'hC);
        $display("split done");
    endtask

    // slot zero issues alone, rest stays held, then an abort clears it
    task automatic t_partial();
        send(blk(mk(5'h08, 1'b0), mk(5'h08, 1'b0), mk(5'h08, 1'b0), EMPTY));
        chk_mask("rdy", 4'h0, {3'h0, o_blk_ready});
        allow = 4'h1;
        cyc(4);
        chk_mask("partial hold", 4'h2, o_group.left);
        i_abort = 1'b1;
        cyc(1);
        i_abort = 1'b0;
        allow = 4'h0;
        chk_mask("abort", 4'h0, o_group.left);
        $display("partial done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog beyond the expected run length
    initial begin
        repeat (20000) @(posedge i_mclk);
        num_errors++;
        end_sim();
    end

    // reset, then the scenarios in turn
    initial begin
        num_errors = 0;
        total_checks = 0;
        i_rst_b = 1'b0;
        i_blk_valid = 1'b0;
        i_blk = '0;
        i_abort = 1'b0;
        allow = 4'h0;
        repeat (2) @(posedge i_mclk);
        #1;
        i_rst_b = 1'b1;
        t_classes();
        t_ipr();
        t_noop();
        t_steer();
        t_ldst();
        t_taken();
        t_nottaken();
        t_split();
        t_partial();
        end_sim();
    end
endmodule
